// ### lmb_mem_model.sv
// Behavioural local memory with address latches.
`timescale 1ns/100ps
`default_nettype none
module lmb_mem_model
  import lmb_pkg::*;
(
  // Clock and strobes.
  input wire logic clk,
  input wire logic address_latch_strobe,
  input wire logic ext_addr_out_zero,
  input wire logic ext_addr_out_two,
  // Driven values and enables.
  input wire logic ext_addr_parity_high_o,
  input wire logic ext_addr_parity_high_oe_n,
  input wire logic ext_addr_parity_low_o,
  input wire logic ext_addr_parity_low_oe_n,
  input wire logic [0:7] mux_bus_high_byte_o,
  input wire logic mux_bus_high_byte_oe_n,
  input wire logic [0:7] mux_bus_low_byte_o,
  input wire logic mux_bus_low_byte_oe_n,
  // Wire levels and latched address.
  output logic ext_addr_parity_high_i,
  output logic ext_addr_parity_low_i,
  output logic [0:7] mux_bus_high_byte_i,
  output logic [0:7] mux_bus_low_byte_i,
  output logic [19:0] lat_addr,
  output logic [1:0] col_bits
);
  logic [15:0] mem [16];
  logic [15:0] q;
  logic [7:0] junk = 8'h00;
  logic [4:0] k = 5'h1f;
  logic ale_q = 1'b0;
  logic rd = 1'b0;
  logic drv = 1'b0;
  // Phase is sampled mid-cycle, counted from the latch strobe rise.
  always @(negedge clk) begin
    ale_q <= address_latch_strobe;
    k <= (address_latch_strobe && !ale_q) ? 5'h00 : (k == 5'h1f ? k : k + 5'h01);
    if (k == 5'h00) lat_addr <= {ext_addr_out_zero, ext_addr_parity_high_o, ext_addr_out_two,
      ext_addr_parity_low_o, mux_bus_high_byte_o, mux_bus_low_byte_o};
    if (k == 5'h04) begin
      rd <= (mux_bus_high_byte_o == STAT_BYTE_RD);
      col_bits <= {ext_addr_out_zero, ext_addr_out_two};
    end
    if (k == 5'h07) drv <= rd;
    if (k == 5'h0e && !rd) mem[lat_addr[3:0]] <= {mux_bus_high_byte_o, mux_bus_low_byte_o};
    if (k == 5'h0f) drv <= 1'b0;
  end
  // Released lines show a pattern that changes every cycle.
  always @(posedge clk) junk <= junk + 8'h5b;
  assign q = mem[lat_addr[3:0]];
  assign mux_bus_high_byte_i = !mux_bus_high_byte_oe_n ? mux_bus_high_byte_o : drv ? q[15:8] : junk;
  assign mux_bus_low_byte_i = !mux_bus_low_byte_oe_n ? mux_bus_low_byte_o : drv ? q[7:0] : ~junk;
  assign ext_addr_parity_high_i = !ext_addr_parity_high_oe_n ? ext_addr_parity_high_o : drv ? ~^q[15:8] : junk[0];
  assign ext_addr_parity_low_i = !ext_addr_parity_low_oe_n ? ext_addr_parity_low_o : drv ? ~^q[7:0] : junk[1];
endmodule // lmb_mem_model
`default_nettype wire

// ### lmb_mux.sv
// Local memory bus front end: quarter sequencer, pin multiplexer and registers.
`timescale 1ns/100ps
`default_nettype none
// Function
// - At any reset, copy the boot strap level into the boot-select control bit.
// - Chapters 0 and 31 are RAM when boot-select is high, ROM when low.
// - With RAM boot chapters, stay off the bus until the halt bit clears.
// - High byte bus: AX4,A0-A6 then status then D0-D7 twice.
// - High byte bus line zero carries the most significant bit.
// - Low byte bus: A7-A14 then AX4,A0-A6 then D8-D15 twice.
// - Low byte bus line zero carries the most significant bit.
// - Pulse the latch strobe at cycle start; full address latched on its fall.
// - Extended output zero drives AX0 in quarter one, then A12.
// - Extended output two drives AX2 in quarter one, then A14.
// - Bus clocks are the input clock over eight; second lags by a quarter period, two input clocks.
// - High parity pin carries AX1, AX0, then high byte parity twice.
// - Low parity pin carries AX3, AX2, then low byte parity twice.
module lmb_mux
  import lmb_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM register slave.
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Straps and reserved pins.
  input wire logic system_reset_pin,
  input wire logic boot_strap_in,
  input wire logic clock_divider_select,
  input wire logic [3:0] reserved_irq_in,
  input wire logic reserved_select_in,
  // Local bus clocks and address strobes.
  output logic local_bus_clock_a,
  output logic local_bus_clock_b,
  output logic address_latch_strobe,
  output logic ext_addr_out_zero,
  output logic ext_addr_out_two,
  // Extended address and parity pins.
  input wire logic ext_addr_parity_high_i,
  output logic ext_addr_parity_high_o,
  output logic ext_addr_parity_high_oe_n,
  input wire logic ext_addr_parity_low_i,
  output logic ext_addr_parity_low_o,
  output logic ext_addr_parity_low_oe_n,
  // Multiplexed byte buses, index 0 is line zero.
  input wire logic [0:7] mux_bus_high_byte_i,
  output logic [0:7] mux_bus_high_byte_o,
  output logic mux_bus_high_byte_oe_n,
  input wire logic [0:7] mux_bus_low_byte_i,
  output logic [0:7] mux_bus_low_byte_o,
  output logic mux_bus_low_byte_oe_n
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [25:0] sync_a;
    logic [25:0] sync_b;
    logic [3:0] cyc;
    logic busy;
    logic pend;
    logic wr;
    logic cur_wr;
    logic [0:19] addr;
    logic [0:15] wdat;
    logic [0:15] rdat;
    logic perr;
    logic boot;
    logic halt;
    logic srst;
    logic [1:0] strap_cnt;
    logic wait_r;
    logic [31:0] rdata;
    logic clka;
    logic clkb;
    logic ale;
    logic ax0;
    logic ax2;
    logic ph_o;
    logic ph_oe_n;
    logic pl_o;
    logic pl_oe_n;
    logic [0:7] hb_o;
    logic hb_oe_n;
    logic [0:7] lb_o;
    logic lb_oe_n;
  } lmb_state_s;

  lmb_state_s st_r;
  lmb_state_s st_nxt;

  // Odd parity bit for one data byte.
  function automatic logic odd_par(input logic [0:7] b);
    odd_par = ~^b;
  endfunction

  // Merge write data into a register under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old & ~m) | (wd & m);
  endfunction

  // Synchronised pin views; only the second stage is read.
  logic s_sysrst;
  logic s_strap;
  logic s_cfg_fault;
  logic s_ph;
  logic s_pl;
  logic [0:7] s_hb;
  logic [0:7] s_lb;
  assign s_sysrst = st_r.sync_b[25];
  assign s_strap = st_r.sync_b[24];
  assign s_cfg_fault = ~st_r.sync_b[23] | ~&st_r.sync_b[22:19] | st_r.sync_b[18];
  assign s_ph = st_r.sync_b[17];
  assign s_pl = st_r.sync_b[16];
  assign s_hb = st_r.sync_b[15:8];
  assign s_lb = st_r.sync_b[7:0];

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  always_comb begin
    logic bus_ok;
    logic adp_rst;
    logic req;
    logic take;
    logic [4:0] chap;
    logic [31:0] ctrl;
    logic [31:0] stat;
    logic [1:0] q;
    logic [2:0] ph;
    bus_ok = 1'b0;
    adp_rst = 1'b0;
    req = 1'b0;
    take = 1'b0;
    chap = '0;
    ctrl = '0;
    stat = '0;
    q = '0;
    ph = '0;
    st_nxt = st_r;

    // Two flip-flop synchroniser for every pin input.
    st_nxt.sync_a = {system_reset_pin, boot_strap_in, clock_divider_select, reserved_irq_in,
                     reserved_select_in, ext_addr_parity_high_i, ext_addr_parity_low_i,
                     mux_bus_high_byte_i, mux_bus_low_byte_i};
    st_nxt.sync_b = st_r.sync_a;

    // Boot chapters and bus permission.
    chap = st_r.addr[0:4];
    bus_ok = ~st_r.boot | ~st_r.halt;
    ctrl = 32'h0;
    ctrl[CTRL_BOOT] = st_r.boot;
    ctrl[CTRL_HALT] = st_r.halt;
    ctrl[CTRL_SRST] = st_r.srst;
    stat = 32'h0;
    stat[STAT_BUSY] = st_r.busy;
    stat[STAT_PEND] = st_r.pend;
    stat[STAT_PERR] = st_r.perr;
    stat[STAT_ROM] = (chap == CHAP_LOW || chap == CHAP_HIGH) & ~st_r.boot;
    stat[STAT_BUS_OK] = bus_ok;
    stat[STAT_CFG_FAULT] = s_cfg_fault;

    // Avalon slave: one wait cycle; a new cycle request stalls while one is pending.
    // Address and data writes also stall while a cycle runs, so its pins stay put.
    req = avs_read | avs_write;
    take = req & ~st_r.wait_r;
    st_nxt.wait_r = 1'b1;
    if (req && st_r.wait_r && !(avs_write && ((avs_address == OFS_ADDR && (st_r.pend || st_r.busy))
        || (avs_address == OFS_WDATA && st_r.busy)))) begin
      st_nxt.wait_r = 1'b0;
      unique case (avs_address)
        OFS_CTRL: st_nxt.rdata = ctrl;
        OFS_ADDR: st_nxt.rdata = {11'h0, st_r.wr, st_r.addr};
        OFS_WDATA: st_nxt.rdata = {16'h0, st_r.wdat};
        OFS_RDATA: st_nxt.rdata = {16'h0, st_r.rdat};
        OFS_STAT: st_nxt.rdata = stat;
        default: st_nxt.rdata = 32'h0;
      endcase
    end
    if (take && avs_write) begin
      unique case (avs_address)
        OFS_CTRL: begin
          ctrl = be_merge(ctrl, avs_writedata, avs_byteenable);
          st_nxt.boot = ctrl[CTRL_BOOT];
          st_nxt.halt = ctrl[CTRL_HALT];
          st_nxt.srst = ctrl[CTRL_SRST];
        end
        OFS_ADDR: begin
          st_nxt.addr = avs_writedata[19:0];
          st_nxt.wr = avs_writedata[ADDR_WR_BIT];
          st_nxt.pend = 1'b1;
        end
        OFS_WDATA: st_nxt.wdat = 16'(be_merge({16'h0, st_r.wdat}, avs_writedata, avs_byteenable));
        default: ;
      endcase
    end

    // Free running quarter sequencer; cycles start only at a boundary.
    st_nxt.cyc = (st_r.cyc == CYC_LAST) ? 4'h0 : st_r.cyc + 4'h1;
    if (st_r.cyc == CYC_LAST) begin
      if (st_r.busy && !st_r.cur_wr) begin
        st_nxt.rdat = {s_hb, s_lb};
        st_nxt.perr = (s_ph != odd_par(s_hb)) | (s_pl != odd_par(s_lb));
      end
      st_nxt.busy = st_r.pend & bus_ok;
      if (st_r.pend && bus_ok) begin
        st_nxt.pend = 1'b0;
        st_nxt.cur_wr = st_r.wr;
      end
    end

    // Adapter reset from the pin or the soft bit reloads the strap.
    adp_rst = s_sysrst | st_r.srst;
    if (st_r.strap_cnt != 2'h0) begin
      st_nxt.strap_cnt = st_r.strap_cnt - 2'h1;
    end
    if (adp_rst || st_r.strap_cnt != 2'h0) begin
      st_nxt.boot = s_strap;
      st_nxt.halt = HALT_RST;
      st_nxt.busy = 1'b0;
      st_nxt.pend = 1'b0;
    end

    // Pin outputs are registered from the next cycle position.
    ph = st_nxt.cyc[2:0];
    q = st_nxt.cyc[3:2];
    st_nxt.clka = ph < CLK_HALF;
    st_nxt.clkb = 3'(ph - CLKB_LAG) < CLK_HALF;
    st_nxt.ale = st_nxt.busy && st_nxt.cyc < ALE_END;
    st_nxt.ax0 = 1'b0;
    st_nxt.ax2 = 1'b0;
    st_nxt.ph_o = 1'b0;
    st_nxt.pl_o = 1'b0;
    st_nxt.hb_o = 8'h00;
    st_nxt.lb_o = 8'h00;
    st_nxt.ph_oe_n = 1'b1;
    st_nxt.pl_oe_n = 1'b1;
    st_nxt.hb_oe_n = 1'b1;
    st_nxt.lb_oe_n = 1'b1;
    if (st_nxt.busy) begin
      unique case (q)
        2'h0: begin
          st_nxt.ax0 = st_nxt.addr[0];
          st_nxt.ax2 = st_nxt.addr[2];
          st_nxt.ph_o = st_nxt.addr[1];
          st_nxt.pl_o = st_nxt.addr[3];
          st_nxt.hb_o = {st_nxt.addr[4], st_nxt.addr[5:11]};
          st_nxt.lb_o = st_nxt.addr[12:19];
        end
        2'h1: begin
          st_nxt.ax0 = st_nxt.addr[17];
          st_nxt.ax2 = st_nxt.addr[19];
          st_nxt.ph_o = st_nxt.addr[0];
          st_nxt.pl_o = st_nxt.addr[2];
          st_nxt.hb_o = st_nxt.cur_wr ? STAT_BYTE_WR : STAT_BYTE_RD;
          st_nxt.lb_o = {st_nxt.addr[4], st_nxt.addr[5:11]};
        end
        default: begin
          st_nxt.ax0 = st_nxt.addr[17];
          st_nxt.ax2 = st_nxt.addr[19];
          st_nxt.ph_o = odd_par(st_nxt.wdat[0:7]);
          st_nxt.pl_o = odd_par(st_nxt.wdat[8:15]);
          st_nxt.hb_o = st_nxt.wdat[0:7];
          st_nxt.lb_o = st_nxt.wdat[8:15];
        end
      endcase
      // Address and status quarters always drive; data quarters only on writes.
      st_nxt.ph_oe_n = q[1] & ~st_nxt.cur_wr;
      st_nxt.pl_oe_n = q[1] & ~st_nxt.cur_wr;
      st_nxt.hb_oe_n = q[1] & ~st_nxt.cur_wr;
      st_nxt.lb_oe_n = q[1] & ~st_nxt.cur_wr;
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.boot <= BOOT_RST;
      st_r.halt <= HALT_RST;
      st_r.srst <= SRST_RST;
      st_r.strap_cnt <= STRAP_CNT_RST;
      st_r.wait_r <= 1'b1;
      st_r.cyc <= CYC_LAST;
      st_r.ph_oe_n <= 1'b1;
      st_r.pl_oe_n <= 1'b1;
      st_r.hb_oe_n <= 1'b1;
      st_r.lb_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.wait_r;
  assign local_bus_clock_a = st_r.clka;
  assign local_bus_clock_b = st_r.clkb;
  assign address_latch_strobe = st_r.ale;
  assign ext_addr_out_zero = st_r.ax0;
  assign ext_addr_out_two = st_r.ax2;
  assign ext_addr_parity_high_o = st_r.ph_o;
  assign ext_addr_parity_high_oe_n = st_r.ph_oe_n;
  assign ext_addr_parity_low_o = st_r.pl_o;
  assign ext_addr_parity_low_oe_n = st_r.pl_oe_n;
  assign mux_bus_high_byte_o = st_r.hb_o;
  assign mux_bus_high_byte_oe_n = st_r.hb_oe_n;
  assign mux_bus_low_byte_o = st_r.lb_o;
  assign mux_bus_low_byte_oe_n = st_r.lb_oe_n;

endmodule // lmb_mux
`default_nettype wire

// ### lmb_mux_bench.sv
// Self-checking bench for the local memory bus multiplexer.
`timescale 1ns/100ps
`default_nettype none
module lmb_mux_bench;
  import lmb_pkg::*;
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, system_reset_pin = 0, boot_strap_in = 0;
  logic [4:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic avs_waitrequest, local_bus_clock_a, local_bus_clock_b, address_latch_strobe;
  logic ext_addr_out_zero, ext_addr_out_two, ext_addr_parity_high_i, ext_addr_parity_high_o;
  logic ext_addr_parity_high_oe_n, ext_addr_parity_low_i, ext_addr_parity_low_o, ext_addr_parity_low_oe_n;
  logic [0:7] mux_bus_high_byte_i, mux_bus_high_byte_o, mux_bus_low_byte_i, mux_bus_low_byte_o;
  logic mux_bus_high_byte_oe_n, mux_bus_low_byte_oe_n;
  logic [19:0] lat;
  logic [1:0] col;
  int failures = 0, comparisons = 0, ale_n = 0;
  // Design under test; straps held as the board must hold them.
  lmb_mux uut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .system_reset_pin, .boot_strap_in, .clock_divider_select(1'b1),
    .reserved_irq_in(4'hf), .reserved_select_in(1'b0), .local_bus_clock_a, .local_bus_clock_b,
    .address_latch_strobe, .ext_addr_out_zero, .ext_addr_out_two, .ext_addr_parity_high_i,
    .ext_addr_parity_high_o, .ext_addr_parity_high_oe_n, .ext_addr_parity_low_i, .ext_addr_parity_low_o,
    .ext_addr_parity_low_oe_n, .mux_bus_high_byte_i, .mux_bus_high_byte_o, .mux_bus_high_byte_oe_n,
    .mux_bus_low_byte_i, .mux_bus_low_byte_o, .mux_bus_low_byte_oe_n);
  lmb_mem_model mem (.clk, .address_latch_strobe, .ext_addr_out_zero, .ext_addr_out_two,
    .ext_addr_parity_high_o, .ext_addr_parity_high_oe_n, .ext_addr_parity_low_o, .ext_addr_parity_low_oe_n,
    .mux_bus_high_byte_o, .mux_bus_high_byte_oe_n, .mux_bus_low_byte_o, .mux_bus_low_byte_oe_n,
    .ext_addr_parity_high_i, .ext_addr_parity_low_i, .mux_bus_high_byte_i, .mux_bus_low_byte_i,
    .lat_addr(lat), .col_bits(col));
  // Clock at 125 MHz, and a count of strobe-high cycles.
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) ale_n <= ale_n + int'(address_latch_strobe === 1'b1);
  // -----------------------------------------------------------------
  // Shared tasks.
  // -----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic idle();
    logic [31:0] s;
    s = 32'h3;
    for (int i = 0; i < 30 && s[1:0] != 2'h0; i++) bus(1'b0, OFS_STAT, 32'h0, s);
    chk(32'(s[1:0]), 32'h0);
  endtask
  // -----------------------------------------------------------------
  // Scenarios.
  // -----------------------------------------------------------------
  task automatic t_ram_boot();
    logic [31:0] q;
    int n0;
    boot_strap_in <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    chk(q, 32'h3);
    n0 = ale_n;
    bus(1'b1, OFS_ADDR, 32'h3, q);
    repeat (40) @(posedge clk);
    bus(1'b0, OFS_STAT, 32'h0, q);
    chk(q, 32'h2);
    chk(32'(ale_n - n0), 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1, q);
    idle();
    chk(32'(ale_n - n0), 32'h2);
  endtask
  task automatic t_data();
    logic [31:0] q;
    logic [19:0] a [2] = '{20'hf_8a5c, 20'h0_73a1};
    logic [15:0] d [2] = '{16'h3c5a, 16'h81e7};
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, OFS_WDATA, {16'h0, d[i]}, q);
      bus(1'b1, OFS_ADDR, {12'h001, a[i]}, q);
      idle();
      chk(32'(lat), 32'(a[i]));
      chk(32'(col), 32'({a[i][2], a[i][0]}));
      bus(1'b1, OFS_ADDR, {12'h000, a[i]}, q);
      idle();
      bus(1'b0, OFS_RDATA, 32'h0, q);
      chk(q, {16'h0, d[i]});
      bus(1'b0, OFS_STAT, 32'h0, q);
      chk(32'(q[2]), 32'h0);
    end
  endtask
  task automatic t_rom_pin();
    logic [31:0] q;
    int n0;
    boot_strap_in <= 1'b0;
    system_reset_pin <= 1'b1;
    repeat (4) @(posedge clk);
    system_reset_pin <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    chk(q, 32'h2);
    n0 = ale_n;
    bus(1'b1, OFS_ADDR, 32'h000f_8001, q);
    bus(1'b0, OFS_STAT, 32'h0, q);
    chk(32'(q[3]), 32'h1);
    idle();
    chk(32'(ale_n - n0), 32'h2);
  endtask
  task automatic t_soft();
    logic [31:0] q;
    bus(1'b0, OFS_ADDR, 32'h0, q);
    chk(q, 32'h000f_8001);
    bus(1'b0, OFS_WDATA, 32'h0, q);
    chk(q, 32'h0000_81e7);
    boot_strap_in <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h4, q);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    chk(q, 32'h7);
    bus(1'b0, 5'h14, 32'h0, q);
    chk(q, 32'h0);
  endtask
  // -----------------------------------------------------------------
  // Verdict, main sequence and watchdog.
  // -----------------------------------------------------------------
  task automatic report_and_stop();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    t_ram_boot();
    t_data();
    t_rom_pin();
    t_soft();
    report_and_stop();
  end
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule // lmb_mux_bench
`default_nettype wire

// ### lmb_mux_properties.sv
// Concurrent checks on the memory side pins of the multiplexer.
`timescale 1ns/100ps
`default_nettype none
module lmb_mux_properties
  import lmb_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Memory side pins.
  input wire logic local_bus_clock_a,
  input wire logic local_bus_clock_b,
  input wire logic address_latch_strobe,
  input wire logic ext_addr_out_zero,
  input wire logic ext_addr_out_two,
  input wire logic ext_addr_parity_high_o,
  input wire logic ext_addr_parity_high_oe_n,
  input wire logic ext_addr_parity_low_o,
  input wire logic ext_addr_parity_low_oe_n,
  input wire logic [0:7] mux_bus_high_byte_o,
  input wire logic mux_bus_high_byte_oe_n,
  input wire logic [0:7] mux_bus_low_byte_o,
  input wire logic mux_bus_low_byte_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // -----------------------------------------------------------------
  // Cycle steps.
  // -----------------------------------------------------------------
  sequence cyc_start;
    $rose(address_latch_strobe);
  endsequence
  sequence rd_status;
    cyc_start ##4 (mux_bus_high_byte_o == STAT_BYTE_RD);
  endsequence
  sequence wr_status;
    cyc_start ##4 (mux_bus_high_byte_o == STAT_BYTE_WR);
  endsequence
  // -----------------------------------------------------------------
  // Assertions.
  // -----------------------------------------------------------------
  chk_ale_pulse: assert property (cyc_start |=> address_latch_strobe ##1 !address_latch_strobe)
    else $error("latch strobe width wrong");
  chk_clk_a_rate: assert property ($rose(local_bus_clock_a) |-> local_bus_clock_a[*4] ##1 !local_bus_clock_a[*4])
    else $error("bus clock a not divide by eight");
  chk_clk_b_lag: assert property ($rose(local_bus_clock_a) |-> ##2 $rose(local_bus_clock_b))
    else $error("bus clock b lag wrong");
  chk_cycle_align: assert property (cyc_start |-> $rose(local_bus_clock_a))
    else $error("cycle not aligned to bus clock");
  chk_quarter_edge: assert property ($changed({mux_bus_high_byte_o, mux_bus_low_byte_o, ext_addr_out_zero,
    ext_addr_out_two}) |-> $changed(local_bus_clock_a))
    else $error("pins changed inside a quarter");
  chk_q1_drive: assert property (cyc_start |-> !mux_bus_high_byte_oe_n && !mux_bus_low_byte_oe_n
    && !ext_addr_parity_high_oe_n && !ext_addr_parity_low_oe_n)
    else $error("buses not driven in quarter one");
  chk_q2_remap: assert property (cyc_start |-> ##4 mux_bus_low_byte_o == $past(mux_bus_high_byte_o, 4)
    && ext_addr_parity_high_o == $past(ext_addr_out_zero, 4)
    && ext_addr_parity_low_o == $past(ext_addr_out_two, 4))
    else $error("quarter two address bits wrong");
  chk_col_hold: assert property (cyc_start |-> ##5 ($stable(ext_addr_out_zero) && $stable(ext_addr_out_two))[*8])
    else $error("column bits moved");
  chk_read_release: assert property (rd_status |-> ##4 (mux_bus_high_byte_oe_n && mux_bus_low_byte_oe_n
    && ext_addr_parity_high_oe_n && ext_addr_parity_low_oe_n)[*8])
    else $error("buses driven during read data");
  chk_write_parity: assert property (wr_status |-> ##4 (^{mux_bus_high_byte_o, ext_addr_parity_high_o}
    && ^{mux_bus_low_byte_o, ext_addr_parity_low_o} && !mux_bus_high_byte_oe_n && !mux_bus_low_byte_oe_n
    && !ext_addr_parity_high_oe_n && !ext_addr_parity_low_oe_n)[*8])
    else $error("write parity not odd");
endmodule // lmb_mux_properties
bind lmb_mux lmb_mux_properties u_props (.clk, .rst, .local_bus_clock_a, .local_bus_clock_b,
  .address_latch_strobe, .ext_addr_out_zero, .ext_addr_out_two, .ext_addr_parity_high_o,
  .ext_addr_parity_high_oe_n, .ext_addr_parity_low_o, .ext_addr_parity_low_oe_n,
  .mux_bus_high_byte_o, .mux_bus_high_byte_oe_n, .mux_bus_low_byte_o,
  .mux_bus_low_byte_oe_n);
`default_nettype wire

// ### lmb_pkg.sv
// Constants for the local memory bus multiplexer.
package lmb_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the Avalon-MM slave.
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_WDATA = 5'h08;
  localparam logic [4:0] OFS_RDATA = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int CTRL_BOOT = 0;
  localparam int CTRL_HALT = 1;
  localparam int CTRL_SRST = 2;
  localparam int ADDR_WR_BIT = 20;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PEND = 1;
  localparam int STAT_PERR = 2;
  localparam int STAT_ROM = 3;
  localparam int STAT_BUS_OK = 4;
  localparam int STAT_CFG_FAULT = 5;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic BOOT_RST = 1'b0;
  localparam logic HALT_RST = 1'b1;
  localparam logic SRST_RST = 1'b0;
  localparam logic [1:0] STRAP_CNT_RST = 2'h3;

  // ----------------------------------------------------------------
  // Timing: bus clocks are the input clock divided by eight, and a
  // memory cycle spans two bus clock periods in four quarters.
  // ----------------------------------------------------------------
  localparam int OSC_DIV = 8;
  localparam logic [2:0] CLK_HALF = 3'(OSC_DIV / 2);
  localparam logic [2:0] CLKB_LAG = 3'(OSC_DIV / 4);
  localparam logic [3:0] CYC_LAST = 4'(2 * OSC_DIV - 1);
  localparam logic [3:0] ALE_END = 4'h2;

  // ----------------------------------------------------------------
  // Memory map and status byte encodings.
  // ----------------------------------------------------------------
  localparam logic [4:0] CHAP_LOW = 5'h00;
  localparam logic [4:0] CHAP_HIGH = 5'h1f;
  localparam logic [7:0] STAT_BYTE_RD = 8'h80;
  localparam logic [7:0] STAT_BYTE_WR = 8'h40;

endpackage
